/* core/lcc_pkg.sv */
// Package of constants and types for the cell charge state machine
package lcc_pkg;

    // ----------------------------
    // Register map (APB byte addresses)
    // ----------------------------
    localparam logic [7:0] LCC_ADDR_CTRL   = 8'h00;
    localparam logic [7:0] LCC_ADDR_STATUS = 8'h04;
    localparam logic [7:0] LCC_ADDR_IRQ_ST = 8'h08;
    localparam logic [7:0] LCC_ADDR_IRQ_MK = 8'h0C;

    // Control field positions
    localparam int LCC_CTRL_SUSP_BIT = 0;
    localparam int LCC_CTRL_TSEL_LSB = 1;
    localparam int LCC_CTRL_FCLR_BIT = 3;

    // Status field positions
    localparam int LCC_ST_ACTIVE_BIT = 0;
    localparam int LCC_ST_FAULT_BIT  = 1;
    localparam int LCC_ST_STATE_LSB  = 4;

    // Interrupt bit positions
    localparam int LCC_IRQ_WIDTH     = 4;
    localparam int LCC_IRQ_FAULT     = 0;
    localparam int LCC_IRQ_DONE      = 1;
    localparam int LCC_IRQ_SUSPEND   = 2;
    localparam int LCC_IRQ_RESTART   = 3;

    // Reset values
    localparam logic       LCC_SUSP_RST  = 1'b0;
    localparam logic [1:0] LCC_TSEL_RST  = 2'h0;
    localparam logic [3:0] LCC_MASK_RST  = 4'h0;

    // Timeout select encodings
    localparam logic [1:0] LCC_TSEL_60   = 2'h0;
    localparam logic [1:0] LCC_TSEL_90   = 2'h1;
    localparam logic [1:0] LCC_TSEL_120  = 2'h2;
    localparam logic [1:0] LCC_TSEL_OFF  = 2'h3;

    // ----------------------------
    // Timing
    // ----------------------------
    localparam longint LCC_CLK_HZ         = 20000000;
    localparam longint LCC_TICK_S         = 1;
    localparam longint LCC_TICK_CYCLES    = LCC_CLK_HZ * LCC_TICK_S;
    localparam int     LCC_TIMO_60_MIN    = 60;
    localparam int     LCC_TIMO_90_MIN    = 90;
    localparam int     LCC_TIMO_120_MIN   = 120;
    localparam int     LCC_EOC_MIN        = 4;
    localparam int     LCC_SEC_PER_MIN    = 60;

    // Current setpoint figures in mA
    localparam logic [10:0] LCC_PRE_MIN_MA = 11'd45;
    localparam logic [10:0] LCC_PRE_DIV    = 11'd10;
    localparam logic [10:0] LCC_THERM_DIV  = 11'd2;

    // ----------------------------
    // Types
    // ----------------------------
    typedef enum logic [2:0] {
        LCC_SUSPEND,
        LCC_PRECOND,
        LCC_FAST,
        LCC_TOPOFF,
        LCC_SLEEP,
        LCC_FAULT
    } lcc_state_t;

    // Comparator results from the analog front end
    typedef struct packed {
        logic vin_ok;
        logic above_bat;
        logic pre_thr;
        logic term_thr;
        logic eoc;
        logic restart;
        logic hot;
    } lcc_cmp_t;

    // Drive to the analog loop
    typedef struct packed {
        logic [10:0] set_ma;
        logic        cc_mode;
        logic        cv_mode;
        logic        hiz;
        logic        therm_red;
    } lcc_drive_t;

endpackage : lcc_pkg

/* core/lcc_sync.sv */
// Three-stage synchroniser with agreement filter for slow pins
`timescale 1ns/1ps
module lcc_sync
    import lcc_pkg::*;
#(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // Pin side
    input  wire logic [W-1:0] din,
    // Filtered result
    output logic      [W-1:0] dout
);
    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;
    logic [W-1:0] dout_next;

    // Take a new value only where stages two and three agree
    assign dout_next = (s2_reg & s3_reg) | (dout & (s2_reg | s3_reg));

    // Shift chain; first stage read only by the second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
            dout   <= '0;
        end else begin
            s1_reg <= din;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            dout   <= dout_next;
        end
    end
endmodule : lcc_sync

/* core/lcc_timer.sv */
// Prescaled seconds counter with restart and terminal compare
`timescale 1ns/1ps
module lcc_timer
    import lcc_pkg::*;
#(
    parameter longint TICK_CYCLES = LCC_TICK_CYCLES
) (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // Control
    input  wire logic        clear,
    input  wire logic        run,
    input  wire logic [15:0] limit_s,
    // Result
    output logic             expired
);
    logic [31:0] pre_reg;
    logic [15:0] sec_reg;
    logic        tick;

    // One-second enable pulse from the prescaler
    assign tick = (pre_reg == 32'(TICK_CYCLES - 1));

    // Clear wins so that a broken condition starts the count afresh
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_reg <= 32'h0;
            sec_reg <= 16'h0;
            expired <= 1'b0;
        end else if (clear || !run) begin
            pre_reg <= 32'h0;
            sec_reg <= 16'h0;
            expired <= 1'b0;
        end else begin
            pre_reg <= tick ? 32'h0 : pre_reg + 32'h1;
            if (tick && sec_reg != limit_s)
                sec_reg <= sec_reg + 16'h1;
            expired <= (sec_reg == limit_s);
        end
    end
endmodule : lcc_timer

/* core/lcc_charger.sv */
// Charge state machine with APB register file and interrupt logic
//
// Chosen here: the APB register port and the register offsets.
`timescale 1ns/1ps
module lcc_charger
    import lcc_pkg::*;
#(
    parameter longint TICK_CYCLES = LCC_TICK_CYCLES
) (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Analog comparators
    input  wire lcc_cmp_t    cmp_in,
    input  wire logic        level_floating,
    input  wire logic [10:0] fast_ma,
    // Analog drive and indicator
    output lcc_drive_t       drive,
    output logic             charge_indicator_n,
    output logic             charge_indicator_oe,
    output logic             irq
);
    // ----------------------------
    // Input synchronisation
    // ----------------------------
    lcc_cmp_t   cmp;
    logic       float_s;
    logic [7:0] sync_raw;
    logic [7:0] sync_out;

    assign sync_raw = {cmp_in, level_floating};
    assign cmp      = lcc_cmp_t'(sync_out[7:1]);
    assign float_s  = sync_out[0];

    lcc_sync #(.W(8)) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .din     (sync_raw),
        .dout    (sync_out)
    );

    // ----------------------------
    // Registers
    // ----------------------------
    lcc_state_t state_reg;
    lcc_state_t state_next;
    logic       suspend_request_bit;
    logic [1:0] safety_timeout_select;
    logic       timeout_fault_flag;
    logic       timeout_fault_next;
    logic       charge_active_flag;
    logic [3:0] irq_st_reg;
    logic [3:0] irq_st_next;
    logic [3:0] irq_mk_reg;
    logic [3:0] irq_ev;

    // ----------------------------
    // APB decode
    // ----------------------------
    logic        acc;
    logic        wr;
    logic        hit_ctrl;
    logic        hit_st;
    logic        hit_irq;
    logic        hit_mk;
    logic        mapped;
    logic        fault_clr;
    logic [31:0] rd_mux;

    assign acc      = psel && penable;
    assign wr       = acc && pwrite && pstrb[0];
    assign hit_ctrl = (paddr == LCC_ADDR_CTRL);
    assign hit_st   = (paddr == LCC_ADDR_STATUS);
    assign hit_irq  = (paddr == LCC_ADDR_IRQ_ST);
    assign hit_mk   = (paddr == LCC_ADDR_IRQ_MK);
    assign mapped   = hit_ctrl | hit_st | hit_irq | hit_mk;
    assign fault_clr = wr && hit_ctrl && pwdata[LCC_CTRL_FCLR_BIT];

    // Read data selection; unused bits read zero
    assign rd_mux =
        hit_ctrl ? {29'h0, safety_timeout_select, suspend_request_bit} :
        hit_st   ? {25'h0, state_reg, 2'h0, timeout_fault_flag, charge_active_flag} :
        hit_irq  ? {28'h0, irq_st_reg} :
        hit_mk   ? {28'h0, irq_mk_reg} : 32'h0;

    // Zero-wait answer: pready rises in the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            prdata  <= (psel && !penable && !pwrite) ? rd_mux : 32'h0;
        end
    end

    // Control and mask registers; writes land on the access edge
    logic wr_ok;
    assign wr_ok = wr && pready && mapped;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            suspend_request_bit   <= LCC_SUSP_RST;
            safety_timeout_select <= LCC_TSEL_RST;
            irq_mk_reg            <= LCC_MASK_RST;
        end else if (wr_ok && hit_ctrl) begin
            suspend_request_bit   <= pwdata[LCC_CTRL_SUSP_BIT];
            safety_timeout_select <= pwdata[LCC_CTRL_TSEL_LSB +: 2];
        end else if (wr_ok && hit_mk) begin
            irq_mk_reg <= pwdata[LCC_IRQ_WIDTH-1:0];
        end
    end

    // ----------------------------
    // Timers
    // ----------------------------
    logic        pre_clear;
    logic        pre_run;
    logic        pre_exp;
    logic [15:0] pre_limit;
    logic        eoc_clear;
    logic        eoc_run;
    logic        eoc_exp;

    // Safety limit in seconds from the select field
    assign pre_limit =
        (safety_timeout_select == LCC_TSEL_90)  ? 16'(LCC_TIMO_90_MIN * LCC_SEC_PER_MIN) :
        (safety_timeout_select == LCC_TSEL_120) ? 16'(LCC_TIMO_120_MIN * LCC_SEC_PER_MIN) :
                                                  16'(LCC_TIMO_60_MIN * LCC_SEC_PER_MIN);
    assign pre_run   = (state_reg == LCC_PRECOND) && (safety_timeout_select != LCC_TSEL_OFF);
    assign pre_clear = (state_reg == LCC_SUSPEND);

    lcc_timer #(.TICK_CYCLES(TICK_CYCLES)) u_pre_tmr (
        .pclk    (pclk),
        .presetn (presetn),
        .clear   (pre_clear),
        .run     (pre_run),
        .limit_s (pre_limit),
        .expired (pre_exp)
    );

    // End-of-charge persistence restarts whenever the condition breaks
    assign eoc_run   = (state_reg == LCC_TOPOFF) && cmp.eoc;
    assign eoc_clear = !cmp.eoc;

    lcc_timer #(.TICK_CYCLES(TICK_CYCLES)) u_eoc_tmr (
        .pclk    (pclk),
        .presetn (presetn),
        .clear   (eoc_clear),
        .run     (eoc_run),
        .limit_s (16'(LCC_EOC_MIN * LCC_SEC_PER_MIN)),
        .expired (eoc_exp)
    );

    // ----------------------------
    // State machine
    // ----------------------------
    logic supply_good;
    logic start_ok;

    assign supply_good = cmp.vin_ok && cmp.above_bat;
    assign start_ok    = supply_good && !float_s && !suspend_request_bit
                         && !timeout_fault_flag;

    // Supply loss overrides every state; fault waits for a clear in SUSPEND
    always_comb begin
        state_next = state_reg;
        if (!supply_good) begin
            state_next = LCC_SUSPEND;
        end else begin
            unique case (state_reg)
                LCC_SUSPEND: if (start_ok) state_next = LCC_PRECOND;
                LCC_PRECOND: begin
                    if (suspend_request_bit || float_s) state_next = LCC_SUSPEND;
                    else if (cmp.pre_thr) state_next = LCC_FAST;
                    else if (pre_exp) state_next = LCC_FAULT;
                end
                LCC_FAST: begin
                    if (suspend_request_bit || float_s) state_next = LCC_SUSPEND;
                    else if (cmp.term_thr) state_next = LCC_TOPOFF;
                end
                LCC_TOPOFF: begin
                    if (suspend_request_bit || float_s) state_next = LCC_SUSPEND;
                    else if (eoc_exp) state_next = LCC_SLEEP;
                end
                LCC_SLEEP: begin
                    if (suspend_request_bit || float_s) state_next = LCC_SUSPEND;
                    else if (cmp.restart) state_next = LCC_PRECOND;
                end
                LCC_FAULT: if (suspend_request_bit || fault_clr) state_next = LCC_SUSPEND;
                default: state_next = LCC_SUSPEND;
            endcase
        end
    end

    // Fault flag: entry sets it and wins over a software clear
    assign timeout_fault_next = (state_next == LCC_FAULT) ? 1'b1 :
                                (fault_clr ? 1'b0 : timeout_fault_flag);

    // Events into sticky interrupt status; set wins over write-one-clear
    assign irq_ev[LCC_IRQ_FAULT]   = (state_next == LCC_FAULT) && (state_reg != LCC_FAULT);
    assign irq_ev[LCC_IRQ_DONE]    = (state_next == LCC_SLEEP) && (state_reg != LCC_SLEEP);
    assign irq_ev[LCC_IRQ_SUSPEND] = (state_next == LCC_SUSPEND) && (state_reg != LCC_SUSPEND);
    assign irq_ev[LCC_IRQ_RESTART] = (state_reg == LCC_SLEEP) && (state_next == LCC_PRECOND);
    assign irq_st_next = irq_ev |
        (irq_st_reg & ~((wr_ok && hit_irq) ? pwdata[LCC_IRQ_WIDTH-1:0] : 4'h0));

    // State, flags and interrupt; asynchronous reset loads SUSPEND
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg          <= LCC_SUSPEND;
            timeout_fault_flag <= 1'b0;
            charge_active_flag <= 1'b0;
            irq_st_reg         <= 4'h0;
            irq                <= 1'b0;
        end else begin
            state_reg          <= state_next;
            timeout_fault_flag <= timeout_fault_next;
            charge_active_flag <= state_next inside {LCC_PRECOND, LCC_FAST, LCC_TOPOFF};
            irq_st_reg         <= irq_st_next;
            irq                <= |(irq_st_next & irq_mk_reg);
        end
    end

    // ----------------------------
    // Analog drive
    // ----------------------------
    logic [10:0] pre_ma;
    logic [10:0] base_ma;
    logic        chg_on;

    assign pre_ma  = (fast_ma / LCC_PRE_DIV > LCC_PRE_MIN_MA) ?
                     fast_ma / LCC_PRE_DIV : LCC_PRE_MIN_MA;
    assign chg_on  = state_next inside {LCC_PRECOND, LCC_FAST, LCC_TOPOFF};
    assign base_ma = (state_next == LCC_PRECOND) ? pre_ma :
                     chg_on ? fast_ma : 11'h000;

    // Hot die halves the setpoint; outputs registered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drive               <= '{set_ma: 11'h000, cc_mode: 1'b0, cv_mode: 1'b0,
                                     hiz: 1'b1, therm_red: 1'b0};
            charge_indicator_n  <= 1'b1;
            charge_indicator_oe <= 1'b0;
        end else begin
            drive.set_ma        <= cmp.hot ? base_ma / LCC_THERM_DIV : base_ma;
            drive.therm_red     <= cmp.hot && chg_on;
            drive.cc_mode       <= state_next inside {LCC_PRECOND, LCC_FAST};
            drive.cv_mode       <= (state_next == LCC_TOPOFF);
            drive.hiz           <= !chg_on;
            charge_indicator_n  <= 1'b0;
            charge_indicator_oe <= chg_on;
        end
    end

endmodule : lcc_charger

/* tb/lcc_cmp_model.sv */
// Comparator front end model driven by bench levels
`timescale 1ns/1ps
module lcc_cmp_model
    import lcc_pkg::*;
(
    // Clock
    input  wire logic     pclk,
    // Bench levels and pace
    input  wire lcc_cmp_t want,
    input  wire logic     slow,
    // Comparator results
    output lcc_cmp_t      cmp
);
    lcc_cmp_t mid_reg;

    // Slow pace adds one cycle of settling, as a lagging comparator would
    always_ff @(posedge pclk) begin
        mid_reg <= want;
        cmp     <= slow ? mid_reg : want;
    end
endmodule : lcc_cmp_model

/* tb/lcc_charger_sva.sv */
// Port checker for the charge state machine
`timescale 1ns/1ps
module lcc_charger_sva
    import lcc_pkg::*;
#(
    parameter longint TICK_CYCLES = LCC_TICK_CYCLES
) (
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic        pready,
    input wire logic        pslverr,
    // Analog side
    input wire lcc_cmp_t    cmp_in,
    input wire logic        level_floating,
    input wire logic [10:0] fast_ma,
    input wire lcc_drive_t  drive,
    input wire logic        charge_indicator_oe
);
    // ----------------------------
    // Helper logic
    // ----------------------------
    localparam longint EOC_CYC = (LCC_EOC_MIN * LCC_SEC_PER_MIN - 1) * TICK_CYCLES;
    localparam longint PRE_CYC = LCC_TIMO_120_MIN * LCC_SEC_PER_MIN * TICK_CYCLES + 40;
    logic [10:0] pre_ma;
    logic        ok_now;
    logic        ctrl_wr;
    logic        susp_reg;
    logic        toff_reg;
    longint      eoc_reg;
    longint      pre_reg;
    longint      ok_reg;

    // Expected precharge level and a shadow of the control word
    assign pre_ma  = (fast_ma / LCC_PRE_DIV > LCC_PRE_MIN_MA) ? fast_ma / LCC_PRE_DIV
                                                              : LCC_PRE_MIN_MA;
    assign ctrl_wr = psel && penable && pready && pwrite && paddr == LCC_ADDR_CTRL && pstrb[0];
    assign ok_now  = cmp_in.vin_ok && cmp_in.above_bat && !level_floating && !susp_reg;

    // Run lengths; a disabled timer has no bound, so that count is held at zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            susp_reg <= 1'b0;
            toff_reg <= 1'b0;
            eoc_reg  <= 0;
            pre_reg  <= 0;
            ok_reg   <= 0;
        end else begin
            susp_reg <= ctrl_wr ? pwdata[0] : susp_reg;
            toff_reg <= ctrl_wr ? (pwdata[2:1] == LCC_TSEL_OFF) : toff_reg;
            eoc_reg  <= cmp_in.eoc ? eoc_reg + 1 : 0;
            ok_reg   <= ok_now ? ok_reg + 1 : 0;
            pre_reg  <= (drive.cc_mode && drive.set_ma == pre_ma && !toff_reg) ? pre_reg + 1 : 0;
        end
    end

    // ----------------------------
    // Properties
    // ----------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_hiz_off;
        drive.hiz |-> drive.set_ma == 11'h000 && !drive.cc_mode && !drive.cv_mode;
    endproperty
    a_hiz_off: assert property (p_hiz_off) else $error("current selected while isolated");

    property p_ind;
        charge_indicator_oe == !drive.hiz && charge_indicator_oe == (drive.cc_mode || drive.cv_mode);
    endproperty
    a_ind: assert property (p_ind) else $error("indicator disagrees with charge mode");

    property p_supply;
        (!(cmp_in.vin_ok && cmp_in.above_bat)) [*8] |-> drive.hiz;
    endproperty
    a_supply: assert property (p_supply) else $error("bad supply left battery connected");

    property p_float;
        level_floating [*8] |-> drive.hiz;
    endproperty
    a_float: assert property (p_float) else $error("floating level pin did not stop charge");

    property p_pre;
        drive.cc_mode && !drive.therm_red && drive.set_ma != fast_ma |-> drive.set_ma == pre_ma;
    endproperty
    a_pre: assert property (p_pre) else $error("precharge level wrong");

    property p_full;
        drive.cv_mode && !drive.therm_red |-> drive.set_ma == fast_ma;
    endproperty
    a_full: assert property (p_full) else $error("top-off level wrong");

    property p_hot;
        cmp_in.hot [*8] ##0 !drive.hiz |-> drive.therm_red &&
            (drive.set_ma == fast_ma / 11'h002 || drive.set_ma == pre_ma / 11'h002);
    endproperty
    a_hot: assert property (p_hot) else $error("hot die did not reduce current");

    property p_eoc;
        $rose(drive.hiz) && $past(drive.cv_mode) && ok_reg > 16 |-> eoc_reg >= EOC_CYC;
    endproperty
    a_eoc: assert property (p_eoc) else $error("top-off ended before end of charge held");

    property p_pre_lim;
        pre_reg < PRE_CYC;
    endproperty
    a_pre_lim: assert property (p_pre_lim) else $error("precharge outlived its timer");

    property p_rdy;
        psel && !penable |=> pready ##1 !pready;
    endproperty
    a_rdy: assert property (p_rdy) else $error("bus answer not one access cycle");

    property p_err;
        pslverr |-> pready && psel && penable;
    endproperty
    a_err: assert property (p_err) else $error("error flag outside an answer");

    // Main scenarios
    c_sleep: cover property ($rose(drive.hiz) && $past(drive.cv_mode));
    c_fast:  cover property (drive.cc_mode && drive.set_ma == fast_ma);
    c_err:   cover property (pslverr);
endmodule : lcc_charger_sva

bind lcc_charger lcc_charger_sva #(.TICK_CYCLES(TICK_CYCLES)) u_sva (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .pslverr(pslverr),
    .cmp_in(cmp_in), .level_floating(level_floating), .fast_ma(fast_ma), .drive(drive),
    .charge_indicator_oe(charge_indicator_oe)
);

/* tb/tb_top.sv */
// Self-checking bench for the charge state machine
`timescale 1ns/1ps
module tb_top;
    import lcc_pkg::*;
    localparam int TICK = 10;
    typedef struct {logic [31:0] data; logic err; logic rd;} lcc_note_t;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        level_floating, slow, irq, ind_n, ind_oe;
    logic [7:0]  paddr;
    logic [3:0]  pstrb;
    logic [31:0] pwdata, prdata, rnd;
    logic [10:0] fast_ma, pre;
    lcc_cmp_t    want, cmp_in;
    lcc_drive_t  drive;
    lcc_note_t   notes[$];
    lcc_note_t   note;
    int          num_errors, compares, cycles;

    // ----------------------------
    // Clock, design and far side
    // ----------------------------
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    lcc_charger #(.TICK_CYCLES(TICK)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cmp_in(cmp_in), .level_floating(level_floating),
        .fast_ma(fast_ma), .drive(drive), .charge_indicator_n(ind_n),
        .charge_indicator_oe(ind_oe), .irq(irq));
    lcc_cmp_model u_cmp (.pclk(pclk), .want(want), .slow(slow), .cmp(cmp_in));

    // ----------------------------
    // Helpers
    // ----------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic step(input int n);
        repeat (n) @(posedge pclk);
    endtask : step
    // Request held until pready is sampled high; the note goes in first
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [31:0] e);
        notes.push_back('{e, a > LCC_ADDR_IRQ_MK, !w});
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 32'h0);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0, e);
    endtask : rd
    task automatic st(input lcc_state_t s, input logic flt);
        rd(LCC_ADDR_STATUS, {25'h0, s, 2'h0, flt, s inside {LCC_PRECOND, LCC_FAST, LCC_TOPOFF}});
    endtask : st
    task automatic chk_drv(input logic [10:0] ma, input logic cc, input logic cv);
        chk("set_ma", ma, drive.set_ma);
        chk("modes", {cc, cv, !(cc || cv)}, {drive.cc_mode, drive.cv_mode, drive.hiz});
        chk("indicator", {cc || cv, 1'b0}, {ind_oe, ind_n});
    endtask : chk_drv
    task automatic close_out();
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : close_out

    // Answer watcher takes the oldest note at each completed transfer
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1) begin
            note = notes.pop_front();
            chk("pslverr", note.err, pslverr);
            if (note.rd) begin
                chk("prdata", note.data, prdata);
            end
        end
    end
    // A hang is cut short well after the longest timer run
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 60000) begin
            num_errors++;
            $display("ERROR run expected end seen timeout");
            close_out();
        end
    end

    // ----------------------------
    // Main sequence
    // ----------------------------
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, level_floating, slow} = '0;
        pstrb = 4'hF;
        want = '0;
        rnd = lfsr(32'hCE42FDA1);
        fast_ma = 11'h12C + 11'(rnd % 32'h2BD);
        pre = (fast_ma / 11'h00A > 11'h02D) ? fast_ma / 11'h00A : 11'h02D;
        step(5);
        presetn <= 1'b1;
        rd(LCC_ADDR_CTRL, 32'h0);
        st(LCC_SUSPEND, 1'b0);
        rd(LCC_ADDR_IRQ_MK, 32'h0);
        rd(8'h10, 32'h0);
        chk_drv(11'h000, 1'b0, 1'b0);
        for (int i = 0; i < 4; i++) begin
            wr(LCC_ADDR_CTRL, 32'(i * 2 + 1));
            rd(LCC_ADDR_CTRL, 32'(i * 2 + 1));
        end
        pstrb <= 4'hE;
        wr(LCC_ADDR_CTRL, 32'h0);
        pstrb <= 4'hF;
        rd(LCC_ADDR_CTRL, 32'h7);
        want.vin_ok    <= 1'b1;
        want.above_bat <= 1'b1;
        step(12);
        st(LCC_SUSPEND, 1'b0);
        wr(LCC_ADDR_CTRL, 32'h0);
        step(12);
        st(LCC_PRECOND, 1'b0);
        chk_drv(pre, 1'b1, 1'b0);
        want.pre_thr <= 1'b1;
        step(12);
        chk_drv(fast_ma, 1'b1, 1'b0);
        want.hot <= 1'b1;
        step(12);
        chk("therm", {1'b1, fast_ma / 11'h002}, {drive.therm_red, drive.set_ma});
        want.hot      <= 1'b0;
        want.term_thr <= 1'b1;
        step(12);
        st(LCC_TOPOFF, 1'b0);
        chk_drv(fast_ma, 1'b0, 1'b1);
        wr(LCC_ADDR_IRQ_ST, 32'hF);
        wr(LCC_ADDR_IRQ_MK, 32'h2);
        // A broken end-of-charge run restarts the count
        want.eoc <= 1'b1;
        rnd = lfsr(rnd);
        step(TICK * (100 + int'(rnd % 32'h64)));
        want.eoc <= 1'b0;
        step(12);
        want.eoc <= 1'b1;
        step(TICK * 230);
        st(LCC_TOPOFF, 1'b0);
        chk("irq", 32'h0, irq);
        step(TICK * 20);
        st(LCC_SLEEP, 1'b0);
        chk_drv(11'h000, 1'b0, 1'b0);
        chk("irq", 32'h1, irq);
        wr(LCC_ADDR_IRQ_ST, 32'h2);
        step(3);
        chk("irq", 32'h0, irq);
        {want.eoc, want.term_thr, want.pre_thr, want.restart} <= 4'h1;
        step(12);
        st(LCC_PRECOND, 1'b0);
        want.restart <= 1'b0;
        // No threshold: precharge runs into the 60 minute timer
        step(TICK * 3600 - 400);
        st(LCC_PRECOND, 1'b0);
        step(600);
        st(LCC_FAULT, 1'b1);
        chk_drv(11'h000, 1'b0, 1'b0);
        want.pre_thr <= 1'b1;
        step(12);
        st(LCC_FAULT, 1'b1);
        wr(LCC_ADDR_CTRL, 32'h8);
        step(12);
        st(LCC_FAST, 1'b0);
        wr(LCC_ADDR_CTRL, 32'h1);
        level_floating <= 1'b1;
        step(12);
        st(LCC_SUSPEND, 1'b0);
        wr(LCC_ADDR_CTRL, 32'h0);
        step(12);
        st(LCC_SUSPEND, 1'b0);
        level_floating <= 1'b0;
        slow <= 1'b1;
        for (int i = 0; i < 2; i++) begin
            {want.vin_ok, want.above_bat} <= 2'h3;
            step(14);
            st(LCC_FAST, 1'b0);
            want.vin_ok    <= i[0];
            want.above_bat <= !i[0];
            step(14);
            st(LCC_SUSPEND, 1'b0);
        end
        close_out();
    end
endmodule : tb_top
